// ===== tls_regs.vh
`ifndef TLS_REGS_VH
`define TLS_REGS_VH
// instruction codes
`define TLS_IR_W       5
`define TLS_IR_CAP     5'h01
`define TLS_I_CREG     5'h04
`define TLS_I_NCU      5'h05
`define TLS_I_ADDR     5'h08
`define TLS_I_RD       5'h09
`define TLS_I_DECNT    5'h0a
`define TLS_I_DCR      5'h0b
`define TLS_I_SHCORE   5'h0c
`define TLS_I_SHL2     5'h0d
`define TLS_I_MBMODE   5'h10
`define TLS_I_MBBYP    5'h11
`define TLS_I_MBSTART  5'h12
`define TLS_I_MBABORT  5'h13
`define TLS_I_MBRES    5'h14
`define TLS_I_MBDONE   5'h15
`define TLS_I_MBFAIL   5'h16
`define TLS_I_BYPASS   5'h1f
// register offsets
`define TLS_A_MBMODE   40'h8500000000
`define TLS_A_MBBYP    40'h8500000008
`define TLS_A_MBGO     40'h8500000010
`define TLS_A_MBHALT   40'h8500000018
`define TLS_A_MBRES    40'h8500000020
`define TLS_A_MBDONE   40'h8500000028
`define TLS_A_MBFAIL   40'h8500000030
`define TLS_A_MBWMR    40'h8500000038
`define TLS_A_LBMODE   40'h8500000040
`define TLS_A_LBBYP    40'h8500000048
`define TLS_A_LBGO     40'h8500000050
`define TLS_A_LBDONE   40'h8500000058
`define TLS_A_CKDLY    40'h8500000120
// fields
`define TLS_MODE_LOOP  3
`define TLS_MODE_DIAG  2
`define TLS_MODE_BISI  1
`define TLS_MODE_PAR   0
`define TLS_RES_DONE   1
`define TLS_RES_FAIL   0
// reset values
`define TLS_MBMODE_RST 4'h0
`define TLS_MBBYP_RST  48'h000000000000
`define TLS_MBBYP_ALL  48'hffffffffffff
`define TLS_SMALL_RST  8'h00
// cache read request header
`define TLS_HDR_JTAG   64
`define TLS_HDR_RDCMD  7'h01
// timing
`define TLS_RD_TCKS    7'd64
`endif

// ===== tls_top.v
`include "tls_regs.vh"

// Operation
// - readback bit 0 flags valid data; host re-polls capture and shift
// - test-port cache read changes no memory and has no side effect
// - jtag private access wins; io bus instructions cannot reach these registers
// - trigger output set whenever debug control value top bit set
// - memory self-test mode: loop, diag, init-style, parallel; upper bits reserved
// - power-on phase one writes init-style bit to 1, kept until reprogrammed
// - after phase one, bypass loaded from fuses, all ones when no partial
// - writing 1 to start bit 0 launches memory self-test
// - writing 1 to warm start arms self-test launched after next warm reset
// - writing 1 to abort bit 0 stops memory self-test
// - result register: done bit 1, fail bit 0, clear to 0
// - per-engine done and fail registers, 48 bits each, clear to 0
// - logic self-test mode program/parallel bits and 8-bit bypass field
// - logic start bit 0 launches logic self-test; 8-bit done field
// - 8-bit read-write clock stop delay register, clears to 0
// - shadow registers read-only, captured live without disturbing operation
// - dynamic strand state always tracked; trap fields change only on trap
// - strand records shift bit 117 first, strand 7 near tdo, skip unavailable
// - eight cache bank records captured together, bit 141 first, bank 0 last
module tls_top #(
    parameter CW = 118,
    parameter TW = 54,
    parameter LW = 142,
    parameter NS = 8,
    parameter NB = 8,
    parameter NE = 48
) (
    input  wire              clk,
    input  wire              rst_b,
    input  wire              tck,
    input  wire              tms,
    input  wire              tdi,
    output reg               tdo,
    output reg               tdo_en,
    output reg               l2_rd_req,
    output reg  [39:0]       l2_rd_addr,
    input  wire              l2_rd_ack,
    input  wire [63:0]       l2_rd_data,
    input  wire [NS*(CW-TW)-1:0] core_dyn,
    input  wire [NS*TW-1:0]  core_trap,
    input  wire [NS-1:0]     core_trap_take,
    input  wire [NS-1:0]     strand_avail,
    input  wire [NB*LW-1:0]  l2_err_state,
    input  wire              power_on_reset_phase_one_done,
    input  wire              fuse_partial,
    input  wire [NE-1:0]     fuse_bypass,
    input  wire              warm_rst_done,
    input  wire [NE-1:0]     mb_eng_done,
    input  wire [NE-1:0]     mb_eng_fail,
    input  wire [7:0]        lb_done_in,
    input  wire              sw_req,
    input  wire              sw_wr,
    input  wire [39:0]       sw_addr,
    input  wire [63:0]       sw_wdata,
    output reg               sw_ack,
    output reg  [63:0]       sw_rdata,
    output reg               mb_start,
    output reg               mb_abort,
    output reg  [3:0]        mb_mode,
    output reg  [NE-1:0]     mb_bypass,
    output reg               lb_start,
    output reg  [1:0]        lb_mode,
    output reg  [7:0]        lb_bypass,
    output reg  [7:0]        clkstop_delay,
    output reg               trigger_out
);
    localparam DW = CW - TW;
    localparam TLR = 4'h0, RTI = 4'h1, SDR = 4'h2, CDR = 4'h3;
    localparam SHD = 4'h4, E1D = 4'h5, PDR = 4'h6, E2D = 4'h7;
    localparam UDR = 4'h8, SIR = 4'h9, CIR = 4'ha, SHI = 4'hb;
    localparam E1I = 4'hc, PIR = 4'hd, E2I = 4'he, UIR = 4'hf;

    // pin synchronisers; third tck flop only feeds the edge detect
    reg tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {tck_s1, tck_s2, tck_s3} <= 3'h0;
            {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'h0;
        end
        else
        begin
            {tck_s1, tck_s2, tck_s3} <= {tck, tck_s1, tck_s2};
            {tms_s1, tms_s2, tdi_s1, tdi_s2} <= {tms, tms_s1, tdi, tdi_s1};
        end
    end
    wire rise = tck_s2 & ~tck_s3;
    wire fall = ~tck_s2 & tck_s3;

    reg [3:0] tap_reg, tap_next;
    always @*
    begin
        case (tap_reg)
            TLR: tap_next = tms_s2 ? TLR : RTI;
            RTI: tap_next = tms_s2 ? SDR : RTI;
            SDR: tap_next = tms_s2 ? SIR : CDR;
            CDR: tap_next = tms_s2 ? E1D : SHD;
            SHD: tap_next = tms_s2 ? E1D : SHD;
            E1D: tap_next = tms_s2 ? UDR : PDR;
            PDR: tap_next = tms_s2 ? E2D : PDR;
            E2D: tap_next = tms_s2 ? UDR : SHD;
            UDR: tap_next = tms_s2 ? SDR : RTI;
            SIR: tap_next = tms_s2 ? TLR : CIR;
            CIR: tap_next = tms_s2 ? E1I : SHI;
            SHI: tap_next = tms_s2 ? E1I : SHI;
            E1I: tap_next = tms_s2 ? UIR : PIR;
            PIR: tap_next = tms_s2 ? E2I : PIR;
            E2I: tap_next = tms_s2 ? UIR : SHI;
            UIR: tap_next = tms_s2 ? SDR : RTI;
            default: tap_next = TLR;
        endcase
    end

    reg [4:0]  ir_sr, ir_reg;
    reg [64:0] dr_sr, dr_next;
    reg [64:0] addr_reg;
    reg [63:0] rb_data;
    reg        rb_valid;
    reg [6:0]  rti_cnt;
    reg        rd_sent;
    reg [2:0]  dcr_reg;
    reg [31:0] decnt_reg;
    reg        wmr_arm;
    reg        lb_go_bit;
    reg [7:0]  lb_done_r;
    reg        res_done, res_fail;
    reg [NE-1:0] eng_done_r, eng_fail_r;
    reg [NS*CW-1:0] sh_core;
    reg [NS*TW-1:0] trap_hold;
    reg [NB*LW-1:0] sh_l2;
    reg [6:0]  dr_len;
    reg [64:0] dr_cap;

    wire cap  = rise & (tap_reg == CDR);
    wire shd  = rise & (tap_reg == SHD);
    wire upd  = rise & (tap_reg == UDR);
    wire into_rti = rise & (tap_next == RTI) & (tap_reg != RTI);
    wire into_tlr = rise & (tap_next == TLR) & (tap_reg != TLR);

    // length and capture value per instruction; io bus ones see bypass
    always @*
    begin
        case (ir_reg)
            `TLS_I_ADDR, `TLS_I_RD: dr_len = 7'd65;
            `TLS_I_MBMODE: dr_len = 7'd4;
            `TLS_I_MBBYP, `TLS_I_MBDONE, `TLS_I_MBFAIL: dr_len = 7'd48;
            `TLS_I_MBRES: dr_len = 7'd2;
            `TLS_I_DCR: dr_len = 7'd3;
            `TLS_I_DECNT: dr_len = 7'd32;
            default: dr_len = 7'd1;
        endcase
        case (ir_reg)
            `TLS_I_ADDR: dr_cap = addr_reg;
            `TLS_I_RD: dr_cap = {rb_data, rb_valid};
            `TLS_I_MBMODE: dr_cap = {61'h0, mb_mode};
            `TLS_I_MBBYP: dr_cap = {17'h0, mb_bypass};
            `TLS_I_MBRES: dr_cap = {63'h0, res_done, res_fail};
            `TLS_I_MBDONE: dr_cap = {17'h0, eng_done_r};
            `TLS_I_MBFAIL: dr_cap = {17'h0, eng_fail_r};
            `TLS_I_DCR: dr_cap = {62'h0, dcr_reg};
            `TLS_I_DECNT: dr_cap = {33'h0, decnt_reg};
            default: dr_cap = 65'h0;
        endcase
        dr_next = dr_sr >> 1;
        dr_next[dr_len - 7'd1] = tdi_s2;
    end

    // strand chain; unavailable strands are bypassed
    wire [NS:0] cs;
    assign cs[0] = tdi_s2;
    genvar g;
    generate
        for (g = 0; g < NS; g = g + 1)
        begin : chain
            assign cs[g+1] = strand_avail[g] ? sh_core[g*CW+CW-1] : cs[g];
        end
    endgenerate
    integer i;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trap_hold <= {NS*TW{1'b0}};
            sh_core   <= {NS*CW{1'b0}};
            sh_l2     <= {NB*LW{1'b0}};
        end
        else
        begin
            for (i = 0; i < NS; i = i + 1)
            begin
                if (core_trap_take[i])
                    trap_hold[i*TW +: TW] <= core_trap[i*TW +: TW];
            end
            if (cap && ir_reg == `TLS_I_SHCORE)
            begin
                for (i = 0; i < NS; i = i + 1)
                    sh_core[i*CW +: CW] <= {trap_hold[i*TW +: TW],
                                            core_dyn[i*DW +: DW]};
            end
            else if (shd && ir_reg == `TLS_I_SHCORE)
            begin
                for (i = 0; i < NS; i = i + 1)
                begin
                    if (strand_avail[i])
                        sh_core[i*CW +: CW] <= {sh_core[i*CW +: CW-1], cs[i]};
                end
            end
            // all banks at once, bank 7 at the tdo end
            if (cap && ir_reg == `TLS_I_SHL2)
                sh_l2 <= l2_err_state;
            else if (shd && ir_reg == `TLS_I_SHL2)
                sh_l2 <= {sh_l2[NB*LW-2:0], tdi_s2};
        end
    end

    wire hdr_ok = addr_reg[`TLS_HDR_JTAG] & (addr_reg[63:57] == `TLS_HDR_RDCMD);
    wire sw_we = sw_req & sw_wr;
    wire j_mode = upd & (ir_reg == `TLS_I_MBMODE);
    wire j_byp  = upd & (ir_reg == `TLS_I_MBBYP);
    wire [4:0] ir_now = (tap_reg == UIR) ? ir_sr : ir_reg;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tap_reg <= TLR;
            ir_sr <= 5'h0;
            ir_reg <= `TLS_I_BYPASS;
            dr_sr <= 65'h0;
            addr_reg <= 65'h0;
            rb_data <= 64'h0;
            rb_valid <= 1'b0;
            rti_cnt <= 7'h0;
            rd_sent <= 1'b0;
            l2_rd_req <= 1'b0;
            l2_rd_addr <= 40'h0;
            dcr_reg <= 3'h0;
            decnt_reg <= 32'h0;
            trigger_out <= 1'b0;
            tdo <= 1'b0;
            tdo_en <= 1'b0;
            mb_mode <= `TLS_MBMODE_RST;
            mb_bypass <= `TLS_MBBYP_RST;
            mb_start <= 1'b0;
            mb_abort <= 1'b0;
            wmr_arm <= 1'b0;
            lb_start <= 1'b0;
            lb_go_bit <= 1'b0;
            lb_mode <= 2'h0;
            lb_bypass <= `TLS_SMALL_RST;
            lb_done_r <= `TLS_SMALL_RST;
            clkstop_delay <= `TLS_SMALL_RST;
            res_done <= 1'b0;
            res_fail <= 1'b0;
            eng_done_r <= {NE{1'b0}};
            eng_fail_r <= {NE{1'b0}};
            sw_ack <= 1'b0;
            sw_rdata <= 64'h0;
        end
        else
        begin
            if (rise)
                tap_reg <= tap_next;
            if (rise && tap_reg == CIR)
                ir_sr <= `TLS_IR_CAP;
            else if (rise && tap_reg == SHI)
                ir_sr <= {tdi_s2, ir_sr[4:1]};
            if (rise && tap_reg == UIR)
            begin
                ir_reg <= ir_sr;
                rti_cnt <= 7'h0;
                rd_sent <= 1'b0;
            end
            else if (into_tlr)
                ir_reg <= `TLS_I_BYPASS;
            if (cap)
                dr_sr <= dr_cap;
            else if (shd)
                dr_sr <= dr_next;
            if (upd && ir_reg == `TLS_I_ADDR)
                addr_reg <= dr_sr;
            if (upd && ir_reg == `TLS_I_DCR)
                dcr_reg <= dr_sr[2:0];
            if (upd && ir_reg == `TLS_I_DECNT)
                decnt_reg <= dr_sr[31:0];
            trigger_out <= dcr_reg[2];
            // read sent once 64 idle tck have passed; read only, no store
            l2_rd_req <= 1'b0;
            if (rise && tap_reg == RTI && ir_reg == `TLS_I_RD && !rd_sent)
            begin
                if (rti_cnt == `TLS_RD_TCKS - 7'd1)
                begin
                    rd_sent <= 1'b1;
                    l2_rd_req <= hdr_ok;
                    l2_rd_addr <= addr_reg[40:1];
                end
                else
                    rti_cnt <= rti_cnt + 7'd1;
            end
            // returned word held on this clock before capture sees it
            if (l2_rd_ack)
            begin
                rb_data <= l2_rd_data;
                rb_valid <= 1'b1;
            end
            else if (l2_rd_req)
                rb_valid <= 1'b0;
            if (fall)
            begin
                tdo_en <= (tap_reg == SHD) | (tap_reg == SHI);
                if (tap_reg == SHI)
                    tdo <= ir_sr[0];
                else if (ir_reg == `TLS_I_SHCORE)
                    tdo <= cs[NS];
                else if (ir_reg == `TLS_I_SHL2)
                    tdo <= sh_l2[NB*LW-1];
                else
                    tdo <= dr_sr[0];
            end
            // shared registers: jtag over software, phase one over both
            if (power_on_reset_phase_one_done)
            begin
                mb_mode[`TLS_MODE_BISI] <= 1'b1;
                mb_bypass <= fuse_partial ? fuse_bypass : `TLS_MBBYP_ALL;
            end
            else
            begin
                if (j_mode)
                    mb_mode <= dr_sr[3:0];
                else if (sw_we && sw_addr == `TLS_A_MBMODE)
                    mb_mode <= sw_wdata[3:0];
                if (j_byp)
                    mb_bypass <= dr_sr[NE-1:0];
                else if (sw_we && sw_addr == `TLS_A_MBBYP)
                    mb_bypass <= sw_wdata[NE-1:0];
            end
            if (sw_we && sw_addr == `TLS_A_LBMODE)
                lb_mode <= sw_wdata[1:0];
            if (sw_we && sw_addr == `TLS_A_LBBYP)
                lb_bypass <= sw_wdata[7:0];
            if (sw_we && sw_addr == `TLS_A_CKDLY)
                clkstop_delay <= sw_wdata[7:0];
            if (sw_we && sw_addr == `TLS_A_LBGO)
                lb_go_bit <= sw_wdata[0];
            lb_start <= sw_we & (sw_addr == `TLS_A_LBGO) & sw_wdata[0];
            // launches and stops are single pulses
            mb_start <= (sw_we & (sw_addr == `TLS_A_MBGO) & sw_wdata[0])
                      | (into_rti & (ir_now == `TLS_I_MBSTART))
                      | (warm_rst_done & wmr_arm);
            mb_abort <= (sw_we & (sw_addr == `TLS_A_MBHALT) & sw_wdata[0])
                      | (into_rti & (ir_now == `TLS_I_MBABORT)) | into_tlr;
            // arming wins over a warm reset in the same cycle
            if (sw_we && sw_addr == `TLS_A_MBWMR && sw_wdata[0])
                wmr_arm <= 1'b1;
            else if (warm_rst_done)
                wmr_arm <= 1'b0;
            // status; bypassed engines count as done and never fail
            eng_done_r <= mb_eng_done;
            eng_fail_r <= mb_eng_fail;
            res_done <= &(eng_done_r | mb_bypass);
            res_fail <= |(eng_fail_r & ~mb_bypass);
            lb_done_r <= lb_done_in;
            sw_ack <= sw_req;
            sw_rdata <= 64'h0;
            if (sw_req && !sw_wr)
            begin
                case (sw_addr)
                    `TLS_A_MBMODE: sw_rdata <= {60'h0, mb_mode};
                    `TLS_A_MBBYP:  sw_rdata <= {16'h0, mb_bypass};
                    `TLS_A_MBRES:  sw_rdata <= {62'h0, res_done, res_fail};
                    `TLS_A_MBDONE: sw_rdata <= {16'h0, eng_done_r};
                    `TLS_A_MBFAIL: sw_rdata <= {16'h0, eng_fail_r};
                    `TLS_A_LBMODE: sw_rdata <= {62'h0, lb_mode};
                    `TLS_A_LBBYP:  sw_rdata <= {56'h0, lb_bypass};
                    `TLS_A_LBGO:   sw_rdata <= {63'h0, lb_go_bit};
                    `TLS_A_LBDONE: sw_rdata <= {56'h0, lb_done_r};
                    `TLS_A_CKDLY:  sw_rdata <= {56'h0, clkstop_delay};
                    default:       sw_rdata <= 64'h0;
                endcase
            end
        end
    end
endmodule

// ===== tls_props.sv
`include "tls_regs.vh"
module tls_props #(
    parameter NE = 48
) (
    input logic          clk,
    input logic          rst_b,
    input logic          sw_req,
    input logic          sw_wr,
    input logic [39:0]   sw_addr,
    input logic [63:0]   sw_wdata,
    input logic          sw_ack,
    input logic [63:0]   sw_rdata,
    input logic          mb_start,
    input logic          mb_abort,
    input logic          lb_start,
    input logic [3:0]    mb_mode,
    input logic [NE-1:0] mb_bypass,
    input logic          power_on_reset_phase_one_done,
    input logic          fuse_partial,
    input logic          l2_rd_req,
    input logic [7:0]    clkstop_delay
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire wr = sw_req && sw_wr;
    wire rd = sw_req && !sw_wr;
    logic [63:0] wd_q;
    always_ff @(posedge clk)
        wd_q <= sw_wdata;
    chk_ack_next: assert property (sw_req |=> sw_ack)
        else $error("software access not acknowledged");
    chk_go_pulse: assert property
        (wr && sw_addr == `TLS_A_MBGO && sw_wdata[0] |=> mb_start ##1 !mb_start)
        else $error("start write gave no single pulse");
    chk_halt_pulse: assert property
        (wr && sw_addr == `TLS_A_MBHALT && sw_wdata[0] |=> mb_abort ##1 !mb_abort)
        else $error("abort write gave no single pulse");
    chk_lgo_pulse: assert property
        (wr && sw_addr == `TLS_A_LBGO && sw_wdata[0] |=> lb_start ##1 !lb_start)
        else $error("logic start write gave no single pulse");
    chk_wo_zero: assert property (rd && (sw_addr == `TLS_A_MBGO ||
        sw_addr == `TLS_A_MBHALT || sw_addr == `TLS_A_MBWMR) |=> sw_rdata == 64'h0)
        else $error("write-only register read nonzero");
    chk_mode_read: assert property
        (rd && sw_addr == `TLS_A_MBMODE |=> sw_rdata == {60'h0, $past(mb_mode)})
        else $error("mode readback wrong");
    chk_por_bisi: assert property (power_on_reset_phase_one_done |=> mb_mode[1])
        else $error("phase one did not set init-style bit");
    chk_mode_hold: assert property (!sw_req && !power_on_reset_phase_one_done |=> $stable(mb_mode))
        else $error("mode changed without a write");
    chk_por_skip: assert property (power_on_reset_phase_one_done && !fuse_partial |=> &mb_bypass)
        else $error("skip field not all ones");
    chk_dly_write: assert property
        (wr && sw_addr == `TLS_A_CKDLY && !power_on_reset_phase_one_done |=> clkstop_delay == wd_q[7:0])
        else $error("clock stop delay not written");
    chk_req_lone: assert property (l2_rd_req |=> (!l2_rd_req) [*8])
        else $error("cache read request repeated");
    chk_res_high: assert property
        (rd && sw_addr == `TLS_A_MBRES |=> sw_rdata[63:2] == 62'h0)
        else $error("result reserved bits nonzero");
    cover property (l2_rd_req);
    cover property (power_on_reset_phase_one_done ##1 mb_mode[1]);
    cover property (mb_start);
endmodule
bind tls_top tls_props #(.NE(NE)) u_props (.clk, .rst_b, .sw_req, .sw_wr, .sw_addr,
    .sw_wdata, .sw_ack, .sw_rdata, .mb_start, .mb_abort, .lb_start, .mb_mode, .mb_bypass,
    .power_on_reset_phase_one_done, .fuse_partial, .l2_rd_req, .clkstop_delay);

// ===== tls_jtag_host.sv
`include "tls_regs.vh"
module tls_jtag_host (
    input  logic clk,
    input  logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // 80 ns period; tdo sampled late in the low phase, after its sync delay
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        o = tdo;
        tck = 1'b1;
        repeat (4) @(negedge clk);
        tck = 1'b0;
    endtask
    task automatic tap_reset();
        logic o;
        repeat (5) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
    // starts in idle or update, lsb first; idle=0 stays out of idle
    task automatic scan(input logic ir, input int n, input logic [64:0] din,
                        output logic [64:0] dout, input logic idle);
        logic o;
        dout = '0;
        tick(1'b1, 1'b0, o);
        if (ir)
            tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b0, o);
        if (idle)
            tick(1'b0, 1'b0, o);
    endtask
    // returns once valid or after 20 polls; a single read is ever outstanding
    task automatic cache_read(input logic [39:0] a, output logic [64:0] rb,
                              output int polls);
        logic o;
        scan(1'b1, 5, 65'(`TLS_I_ADDR), rb, 1'b1);
        scan(1'b0, 65, {1'b1, `TLS_HDR_RDCMD, 16'h0, a, 1'b0}, rb, 1'b1);
        scan(1'b1, 5, 65'(`TLS_I_RD), rb, 1'b0);
        repeat (66) tick(1'b0, 1'b0, o);
        polls = 0;
        rb = '0;
        while (rb[0] !== 1'b1 && polls < 20)
        begin
            scan(1'b0, 65, 65'h0, rb, 1'b0);
            polls++;
        end
    endtask
endmodule

// ===== tb.sv
`include "tls_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, l2_rd_ack = 1'b0, power_on_reset_phase_one_done = 1'b0;
    logic fuse_partial = 1'b0, warm_rst_done = 1'b0, sw_req = 1'b0, sw_wr = 1'b0;
    logic [63:0] l2_rd_data = 64'h0, sw_wdata = 64'h0, l2_word = 64'h0;
    logic [511:0] core_dyn = '0;
    logic [431:0] core_trap = '0;
    logic [7:0] core_trap_take = 8'h0, strand_avail = 8'h7f, lb_done_in = 8'h0;
    logic [1135:0] l2_err_state = '0;
    logic [47:0] fuse_bypass = 48'h0, mb_eng_done = 48'h0, mb_eng_fail = 48'h0;
    logic [39:0] sw_addr = 40'h0, rd_addr_exp = 40'h0;
    logic tck, tms, tdi, tdo, tdo_en, l2_rd_req, sw_ack, mb_start, mb_abort;
    logic lb_start, trigger_out;
    logic [39:0] l2_rd_addr;
    logic [63:0] sw_rdata;
    logic [3:0] mb_mode;
    logic [47:0] mb_bypass;
    logic [1:0] lb_mode;
    logic [7:0] lb_bypass, clkstop_delay;
    int err_total = 0, checks_done = 0, go_n = 0, halt_n = 0, ack_dly = 1;
    logic [39:0] wa [7] = '{`TLS_A_MBMODE, `TLS_A_MBBYP, `TLS_A_LBMODE, `TLS_A_LBBYP,
        `TLS_A_LBGO, `TLS_A_CKDLY, `TLS_A_MBRES};
    logic [63:0] wm [7] = '{64'hf, 64'hffffffffffff, 64'h3, 64'hff, 64'h1, 64'hff, 64'h0};
    logic [39:0] za [8] = '{`TLS_A_MBGO, `TLS_A_MBHALT, `TLS_A_MBWMR, `TLS_A_MBDONE,
        `TLS_A_MBFAIL, `TLS_A_LBDONE, `TLS_A_MBRES, 40'h8500000100};
    tls_top dut (.clk, .rst_b, .tck, .tms, .tdi, .tdo, .tdo_en, .l2_rd_req, .l2_rd_addr,
        .l2_rd_ack, .l2_rd_data, .core_dyn, .core_trap, .core_trap_take, .strand_avail,
        .l2_err_state, .power_on_reset_phase_one_done, .fuse_partial, .fuse_bypass, .warm_rst_done,
        .mb_eng_done, .mb_eng_fail, .lb_done_in, .sw_req, .sw_wr, .sw_addr, .sw_wdata,
        .sw_ack, .sw_rdata, .mb_start, .mb_abort, .mb_mode, .mb_bypass, .lb_start,
        .lb_mode, .lb_bypass, .clkstop_delay, .trigger_out);
    tls_jtag_host u_host (.clk, .tdo, .tck, .tms, .tdi);
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        if (mb_start === 1'b1)
            go_n++;
        if (mb_abort === 1'b1)
            halt_n++;
    end
    task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic sw(input logic w, input logic [39:0] a, input logic [63:0] d,
                      output logic [63:0] q);
        sw_req = 1'b1;
        sw_wr = w;
        sw_addr = a;
        sw_wdata = d;
        @(negedge clk);
        chk(sw_ack, 1'b1);
        q = sw_rdata;
        sw_req = 1'b0;
        @(negedge clk);
    endtask
    task automatic swr(input logic [39:0] a, input logic [63:0] e);
        logic [63:0] q;
        sw(1'b0, a, 64'h0, q);
        chk(q, e);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // slow answers leave valid low across whole polls; the bus then shows junk
    always @(negedge clk)
        if (l2_rd_req === 1'b1)
        begin
            chk(l2_rd_addr, rd_addr_exp);
            repeat (ack_dly) @(negedge clk);
            l2_rd_data <= l2_word;
            l2_rd_ack <= 1'b1;
            @(negedge clk);
            l2_rd_ack <= 1'b0;
            l2_rd_data <= ~l2_word;
        end
    initial
    begin
        repeat (90000) @(posedge clk);
        err_total++;
        wrap_up();
    end
    initial
    begin
        logic [63:0] q;
        logic [64:0] rb;
        int p;
        l2_err_state[7*142+134 +: 8] = 8'hc5;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        foreach (za[i])
            swr(za[i], 64'h0);
        foreach (wa[i])
        begin
            sw(1'b1, wa[i], '1, q);
            swr(wa[i], wm[i]);
            sw(1'b1, wa[i], 64'h0, q);
        end
        pulse(power_on_reset_phase_one_done);
        swr(`TLS_A_MBMODE, 64'h2);
        swr(`TLS_A_MBBYP, 64'hffffffffffff);
        fuse_partial = 1'b1;
        fuse_bypass = 48'h00000f0f00ff;
        pulse(power_on_reset_phase_one_done);
        swr(`TLS_A_MBBYP, {16'h0, fuse_bypass});
        sw(1'b1, `TLS_A_MBBYP, 64'h10, q);
        mb_eng_done = '1;
        mb_eng_fail = 48'h000000000011;
        lb_done_in = 8'h5a;
        repeat (2) @(negedge clk);
        swr(`TLS_A_MBRES, 64'h3);
        swr(`TLS_A_MBDONE, 64'hffffffffffff);
        swr(`TLS_A_MBFAIL, 64'h11);
        swr(`TLS_A_LBDONE, 64'h5a);
        mb_eng_fail = 48'h000000000010;
        repeat (2) @(negedge clk);
        swr(`TLS_A_MBRES, 64'h2);
        u_host.tap_reset();
        go_n = 0;
        halt_n = 0;
        sw(1'b1, `TLS_A_MBGO, 64'hfffffffffffffffe, q);
        sw(1'b1, `TLS_A_MBGO, 64'h1, q);
        sw(1'b1, `TLS_A_MBHALT, 64'h1, q);
        sw(1'b1, `TLS_A_MBWMR, 64'h1, q);
        chk(go_n, 1);
        chk(halt_n, 1);
        pulse(warm_rst_done);
        chk(go_n, 2);
        u_host.scan(1'b1, 5, 65'(`TLS_I_MBSTART), rb, 1'b1);
        chk(go_n, 3);
        u_host.scan(1'b1, 5, 65'(`TLS_I_MBRES), rb, 1'b1);
        u_host.scan(1'b0, 2, 65'h0, rb, 1'b1);
        chk(rb[1:0], 2'b10);
        for (int c = 4; c < 6; c++)
        begin
            u_host.scan(1'b1, 5, 65'(c), rb, 1'b1);
            u_host.scan(1'b0, 2, 65'h3, rb, 1'b1);
            chk(rb[1:0], 2'b10);
        end
        u_host.scan(1'b1, 5, 65'(`TLS_I_DCR), rb, 1'b1);
        for (int c = 0; c < 8; c++)
        begin
            u_host.scan(1'b0, 3, 65'(c), rb, 1'b1);
            chk(trigger_out, c[2]);
        end
        u_host.scan(1'b1, 5, 65'(`TLS_I_SHL2), rb, 1'b1);
        u_host.scan(1'b0, 8, 65'h0, rb, 1'b1);
        chk(rb[7:0], 8'ha3);
        core_trap[6*54+46 +: 8] = 8'hc5;
        core_trap_take[6] = 1'b1;
        @(negedge clk);
        core_trap_take = 8'h0;
        core_trap = '0;
        u_host.scan(1'b1, 5, 65'(`TLS_I_SHCORE), rb, 1'b1);
        u_host.scan(1'b0, 8, 65'hff, rb, 1'b1);
        chk(rb[7:0], 8'ha3);
        for (int i = 0; i < 2; i++)
        begin
            ack_dly = i ? 700 : 1;
            rd_addr_exp = i ? 40'h0000002468 : 40'h00fedcba98;
            l2_word = i ? 64'hfedcba9876543210 : 64'h0123456789abcdef;
            u_host.cache_read(rd_addr_exp, rb, p);
            chk(rb, {l2_word, 1'b1});
            chk(p > 1, i == 1);
        end
        wrap_up();
    end
endmodule
